// file: event_source_model.sv
// Model of the peripheral event sources that face the flag block.
// Assumes the bench calls pulse() from one thread and only one burst at a time.
`timescale 1ns/1ns
module event_source_model
   import irq_flags_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Events toward the flag block
   output src_event_type src_event_o
);
   initial src_event_o = '0;

   // ------------------------------------------------------------
   // Event pulses
   // ------------------------------------------------------------
   // Kept to one cycle, because a held level would set the flags again on every cycle
   task pulse(input logic [10:0] ev);
      @(posedge clk_i);
      src_event_o <= ev;
      @(posedge clk_i);
      src_event_o <= '0;
   endtask : pulse
endmodule : event_source_model

// file: irq_flags_masks.sv
// Interrupt mask and factor flag registers for the peripheral event sources.
// Assumes event inputs are one-cycle pulses synchronous to clk_i and a classic Wishbone master.

`timescale 1ns/1ns

// Operation
// - Two programmable timer mask bits enable (1) or block (0) their interrupts and clear on reset.
// - The serial interface mask bit sits in bit 0 of its register and resets to 0.
// - One mask bit in bit 0 enables the first key port group as a whole and clears on reset.
// - The second and third key group mask bits sit in bits 1 and 2 of one register and clear on reset.
// - Four clock tap mask bits run from the 16 Hz tap in bit 0 to the 1 Hz tap in bit 3 and reset to 0.
// - The A/D converter mask bit sits in bit 0 of its register and resets to 0.
// - Each factor flag is set by its event, reads 1 while pending, and is 0 after reset.
// - Writing 1 to a factor flag clears it and writing 0 leaves it alone.
// - The serial factor flag sits in bit 0 of its register and behaves like the others.
// - Key group flags sit in bit 0 of one register and bits 1 and 2 of the next.
// - Clock tap flags are bit 3 for 1 Hz, bit 2 for 2 Hz, bit 1 for 8 Hz and bit 0 for 16 Hz.
// - The A/D flag in bit 0 is set by each conversion-complete event and cleared by writing 1.
// - Unused bit positions read as 0 and ignore writes.
module irq_flags_masks
   import irq_flags_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [17:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Peripheral events and request to the core
   input wire src_event_type src_event_i,
   output logic irq_o
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic decode_type decode_addr(input logic [15:0] idx);
      decode_type d;
      d = '0;
      d.hit = 1'b1;
      case (idx)
         PROG_TIMER_IRQ_MASK_IDX: d.slot = SLOT_PTIMER;
         SERIAL_IRQ_MASK_IDX: d.slot = SLOT_SERIAL;
         KEY_GROUP0_IRQ_MASK_IDX: d.slot = SLOT_KEY_A;
         KEY_GROUP12_IRQ_MASK_IDX: d.slot = SLOT_KEY_BC;
         CLOCK_TAP_IRQ_MASK_IDX: d.slot = SLOT_TAP;
         ADC_IRQ_MASK_IDX: d.slot = SLOT_ADC;
         PROG_TIMER_IRQ_FLAGS_IDX: d = '{1'b1, 1'b1, SLOT_PTIMER};
         SERIAL_IRQ_FLAG_IDX: d = '{1'b1, 1'b1, SLOT_SERIAL};
         KEY_GROUP0_IRQ_FLAG_IDX: d = '{1'b1, 1'b1, SLOT_KEY_A};
         KEY_GROUP12_IRQ_FLAGS_IDX: d = '{1'b1, 1'b1, SLOT_KEY_BC};
         CLOCK_TAP_IRQ_FLAGS_IDX: d = '{1'b1, 1'b1, SLOT_TAP};
         ADC_IRQ_FLAG_IDX: d = '{1'b1, 1'b1, SLOT_ADC};
         default: d.hit = 1'b0;
      endcase
      return d;
   endfunction : decode_addr

   // ------------------------------------------------------------
   // Event routing onto register bit positions
   // ------------------------------------------------------------
   function automatic logic [5:0][3:0] event_bits(input src_event_type e);
      logic [5:0][3:0] s;
      s = '0;
      s[SLOT_PTIMER][PTIMER_A_BIT] = e.ptimer_a;
      s[SLOT_PTIMER][PTIMER_B_BIT] = e.ptimer_b;
      s[SLOT_SERIAL][SERIAL_BIT] = e.serial;
      s[SLOT_KEY_A][KEY_GRP_A_BIT] = e.key_grp_a;
      s[SLOT_KEY_BC][KEY_GRP_B_BIT] = e.key_grp_b;
      s[SLOT_KEY_BC][KEY_GRP_C_BIT] = e.key_grp_c;
      s[SLOT_TAP][TAP_16HZ_BIT] = e.tap_16hz;
      s[SLOT_TAP][TAP_8HZ_BIT] = e.tap_8hz;
      s[SLOT_TAP][TAP_2HZ_BIT] = e.tap_2hz;
      s[SLOT_TAP][TAP_1HZ_BIT] = e.tap_1hz;
      s[SLOT_ADC][ADC_DONE_BIT] = e.adc_done;
      return s;
   endfunction : event_bits

   state_type st_reg;
   state_type st_next;
   decode_type dec;
   logic req_go;
   logic wr_go;
   logic [5:0][3:0] ev_bits;

   assign dec = decode_addr(adr_i[17:2]);
   assign req_go = cyc_i && stb_i && !st_reg.ack;
   // Only the lowest byte lane carries register data
   assign wr_go = req_go && we_i && sel_i[0] && dec.hit;
   assign ev_bits = event_bits(src_event_i);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [5:0][3:0] wr_mask;
      logic [5:0][3:0] wr_clear;
      logic pend;
      wr_mask = '0;
      wr_clear = '0;
      pend = 1'b0;
      st_next = st_reg;
      // Single-cycle answer; ack drops the cycle after it was given
      st_next.ack = req_go;
      st_next.rdata = REG_RESET;
      if (req_go && !we_i && dec.hit) begin
         st_next.rdata = dec.is_flag ? st_reg.flag[dec.slot] : st_reg.mask[dec.slot];
      end
      if (wr_go && !dec.is_flag) begin
         wr_mask[dec.slot] = 4'hf;
      end
      if (wr_go && dec.is_flag) begin
         wr_clear[dec.slot] = dat_i[3:0];
      end
      for (int i = 0; i < NUM_SLOTS; i++) begin
         // Unused positions never take a value, so they read back as zero
         st_next.mask[i] = ((st_reg.mask[i] & ~wr_mask[i]) | (dat_i[3:0] & wr_mask[i]))
                           & SLOT_VALID[i];
         // An event in the cycle of a clear still leaves the flag set
         st_next.flag[i] = ((st_reg.flag[i] & ~wr_clear[i]) | ev_bits[i])
                           & SLOT_VALID[i];
         pend = pend | (|(st_next.flag[i] & st_next.mask[i]));
      end
      st_next.irq = pend;
      if (rst_i) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_reg <= st_next;
   end

   assign ack_o = st_reg.ack;
   assign irq_o = st_reg.irq;
   assign dat_o = {28'h0000000, st_reg.rdata};

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic past_wm;
   logic past_wf;
   logic [2:0] past_slot;
   logic [3:0] past_dat;
   logic [5:0][3:0] past_ev;
   logic [3:0] past_old;
   // The old flag word is captured with the slot of the same request, so the check needs no nested history
   always_ff @(posedge clk_i) begin
      past_old <= st_reg.flag[dec.slot];
      past_wm <= wr_go && !dec.is_flag;
      past_wf <= wr_go && dec.is_flag;
      past_slot <= dec.slot;
      past_dat <= dat_i[3:0];
      past_ev <= ev_bits;
   end

   a_ptimer_mask_write: assert property (
      past_wm && past_slot == SLOT_PTIMER |-> st_reg.mask[SLOT_PTIMER] == (past_dat & 4'h3))
      else $error("timer mask write not stored");
   a_serial_mask_write: assert property (
      past_wm && past_slot == SLOT_SERIAL |-> st_reg.mask[SLOT_SERIAL] == {3'h0, past_dat[0]})
      else $error("serial mask write not stored");
   a_key_a_mask: assert property (
      past_wm && past_slot == SLOT_KEY_A |-> st_reg.mask[SLOT_KEY_A][0] == past_dat[0])
      else $error("key group a mask wrong");
   a_key_bc_mask: assert property (
      past_wm && past_slot == SLOT_KEY_BC |-> st_reg.mask[SLOT_KEY_BC] == (past_dat & 4'h6))
      else $error("key group b c mask wrong");
   a_tap_mask_write: assert property (
      past_wm && past_slot == SLOT_TAP |-> st_reg.mask[SLOT_TAP] == past_dat)
      else $error("tap mask write not stored");
   a_adc_mask_write: assert property (
      past_wm && past_slot == SLOT_ADC |-> st_reg.mask[SLOT_ADC] == {3'h0, past_dat[0]})
      else $error("adc mask write not stored");
   a_event_sets_flag: assert property (
      src_event_i.ptimer_b |=> st_reg.flag[SLOT_PTIMER][PTIMER_B_BIT] && irq_o == (|(st_reg.flag & st_reg.mask)))
      else $error("event did not set flag");
   a_flag_w1c_only: assert property (
      past_wf |-> st_reg.flag[past_slot] ==
         (((past_old & ~past_dat) | past_ev[past_slot]) & SLOT_VALID[past_slot]))
      else $error("flag write one to clear wrong");
   a_serial_flag_set: assert property (
      src_event_i.serial |=> st_reg.flag[SLOT_SERIAL] == 4'h1)
      else $error("serial flag not in bit 0");
   a_key_flag_bits: assert property (
      src_event_i.key_grp_c && !wr_go |=> st_reg.flag[SLOT_KEY_BC][KEY_GRP_C_BIT] && st_reg.flag[SLOT_KEY_BC][0] == 1'b0)
      else $error("key flag placement wrong");
   a_tap_1hz_bit: assert property (
      src_event_i.tap_1hz |=> st_reg.flag[SLOT_TAP][TAP_1HZ_BIT])
      else $error("1 hz tap flag not in bit 3");
   a_adc_flag_hold: assert property (
      st_reg.flag[SLOT_ADC][0] && !wr_go ##1 !wr_go [*2] |=> st_reg.flag[SLOT_ADC][0])
      else $error("adc flag lost without clear");
   a_unused_read_zero: assert property (
      ack_o |-> dat_o[31:4] == 28'h0000000 && (st_reg.flag[SLOT_SERIAL][3:1] == 3'h0))
      else $error("unused bits not zero");
   a_irq_level_tracks: assert property (
      irq_o == (|(st_reg.flag & st_reg.mask)))
      else $error("irq does not match flags and masks");

   // ------------------------------------------------------------
   // Per-source flag placement
   // ------------------------------------------------------------
   a_ptimer_a_flag: assert property (
      src_event_i.ptimer_a |=> st_reg.flag[SLOT_PTIMER][PTIMER_A_BIT])
      else $error("timer a flag not set");
   a_key_a_flag: assert property (
      src_event_i.key_grp_a |=> st_reg.flag[SLOT_KEY_A][KEY_GRP_A_BIT])
      else $error("key group a flag not set");
   a_key_b_flag: assert property (
      src_event_i.key_grp_b |=> st_reg.flag[SLOT_KEY_BC][KEY_GRP_B_BIT])
      else $error("key group b flag not set");
   a_tap_16hz_flag: assert property (
      src_event_i.tap_16hz |=> st_reg.flag[SLOT_TAP][TAP_16HZ_BIT])
      else $error("16 hz tap flag not in bit 0");
   a_tap_8hz_flag: assert property (
      src_event_i.tap_8hz |=> st_reg.flag[SLOT_TAP][TAP_8HZ_BIT])
      else $error("8 hz tap flag not in bit 1");
   a_tap_2hz_flag: assert property (
      src_event_i.tap_2hz |=> st_reg.flag[SLOT_TAP][TAP_2HZ_BIT])
      else $error("2 hz tap flag not in bit 2");
   a_adc_flag_set: assert property (
      src_event_i.adc_done |=> st_reg.flag[SLOT_ADC] == 4'h1)
      else $error("adc flag not set in bit 0");

   // ------------------------------------------------------------
   // Reset, read-back and hold behaviour
   // ------------------------------------------------------------
   // Reset is checked on its own, since every other check is switched off while it is high
   a_reset_clears: assert property (disable iff (1'b0)
      rst_i |=> !ack_o && !irq_o && dat_o == 32'h0 && st_reg.mask == '0 && st_reg.flag == '0)
      else $error("reset did not clear the block");
   a_mask_read_back: assert property (
      req_go && !we_i && dec.hit && !dec.is_flag |=> dat_o[3:0] == $past(st_reg.mask[dec.slot]))
      else $error("mask read data wrong");
   a_flag_read_back: assert property (
      req_go && !we_i && dec.hit && dec.is_flag |=> dat_o[3:0] == $past(st_reg.flag[dec.slot]))
      else $error("flag read data wrong");
   a_miss_read_zero: assert property (
      req_go && !we_i && !dec.hit |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_ack_single_pulse: assert property (
      req_go |=> ack_o ##1 !ack_o)
      else $error("acknowledge not a single pulse");
   a_mask_holds: assert property (
      !(wr_go && !dec.is_flag) |=> st_reg.mask == $past(st_reg.mask))
      else $error("mask changed without a write");
   a_flags_no_drop: assert property (
      !(wr_go && dec.is_flag) |=> (st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag))
      else $error("flag dropped without a clear");
   a_unused_stay_zero: assert property (
      (st_reg.mask & SLOT_VALID) == st_reg.mask && (st_reg.flag & SLOT_VALID) == st_reg.flag)
      else $error("unused bit position holds a one");

   c_irq_raised: cover property (!irq_o ##1 irq_o);
   c_flag_cleared: cover property (wr_go && dec.is_flag ##0 irq_o ##1 !irq_o);
   c_reset_while_irq: cover property (disable iff (1'b0) irq_o ##1 rst_i);
   c_set_beats_clear: cover property (wr_go && dec.is_flag && (|ev_bits));
   c_read_flags: cover property (req_go && !we_i && dec.is_flag ##1 ack_o);

endmodule : irq_flags_masks

// file: irq_flags_pkg.sv
// Package for the peripheral interrupt mask and factor flag block.
// Assumes a 32-bit classic Wishbone slave; each register is one word at four times its index.

package irq_flags_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [15:0] PROG_TIMER_IRQ_MASK_IDX = 16'hffe2;
   localparam logic [15:0] SERIAL_IRQ_MASK_IDX = 16'hffe3;
   localparam logic [15:0] KEY_GROUP0_IRQ_MASK_IDX = 16'hffe4;
   localparam logic [15:0] KEY_GROUP12_IRQ_MASK_IDX = 16'hffe5;
   localparam logic [15:0] CLOCK_TAP_IRQ_MASK_IDX = 16'hffe6;
   localparam logic [15:0] ADC_IRQ_MASK_IDX = 16'hffe7;
   localparam logic [15:0] PROG_TIMER_IRQ_FLAGS_IDX = 16'hfff2;
   localparam logic [15:0] SERIAL_IRQ_FLAG_IDX = 16'hfff3;
   localparam logic [15:0] KEY_GROUP0_IRQ_FLAG_IDX = 16'hfff4;
   localparam logic [15:0] KEY_GROUP12_IRQ_FLAGS_IDX = 16'hfff5;
   localparam logic [15:0] CLOCK_TAP_IRQ_FLAGS_IDX = 16'hfff6;
   localparam logic [15:0] ADC_IRQ_FLAG_IDX = 16'hfff7;

   // ------------------------------------------------------------
   // Register slots, implemented bits and reset value
   // ------------------------------------------------------------
   localparam int NUM_SLOTS = 6;
   localparam logic [2:0] SLOT_PTIMER = 3'h0;
   localparam logic [2:0] SLOT_SERIAL = 3'h1;
   localparam logic [2:0] SLOT_KEY_A = 3'h2;
   localparam logic [2:0] SLOT_KEY_BC = 3'h3;
   localparam logic [2:0] SLOT_TAP = 3'h4;
   localparam logic [2:0] SLOT_ADC = 3'h5;
   localparam logic [5:0][3:0] SLOT_VALID = {4'h1, 4'hf, 4'h6, 4'h1, 4'h1, 4'h3};
   localparam logic [3:0] REG_RESET = 4'h0;

   // ------------------------------------------------------------
   // Field positions within the slots
   // ------------------------------------------------------------
   localparam int PTIMER_A_BIT = 0;
   localparam int PTIMER_B_BIT = 1;
   localparam int SERIAL_BIT = 0;
   localparam int KEY_GRP_A_BIT = 0;
   localparam int KEY_GRP_B_BIT = 1;
   localparam int KEY_GRP_C_BIT = 2;
   localparam int TAP_16HZ_BIT = 0;
   localparam int TAP_8HZ_BIT = 1;
   localparam int TAP_2HZ_BIT = 2;
   localparam int TAP_1HZ_BIT = 3;
   localparam int ADC_DONE_BIT = 0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic ptimer_a;
      logic ptimer_b;
      logic serial;
      logic key_grp_a;
      logic key_grp_b;
      logic key_grp_c;
      logic tap_16hz;
      logic tap_8hz;
      logic tap_2hz;
      logic tap_1hz;
      logic adc_done;
   } src_event_type;

   typedef struct packed {
      logic hit;
      logic is_flag;
      logic [2:0] slot;
   } decode_type;

   typedef struct packed {
      logic [5:0][3:0] mask;
      logic [5:0][3:0] flag;
      logic ack;
      logic [3:0] rdata;
      logic irq;
   } state_type;

endpackage : irq_flags_pkg

// file: tb_irq_flags_masks.sv
// Self-checking bench for the interrupt mask and factor flag block.
// Assumes a one-word Wishbone answer per access and the event model beside it.
`timescale 1ns/1ns
module tb_irq_flags_masks
   import irq_flags_pkg::*;
;
   typedef struct packed {logic [10:0] ev; logic [15:0] idx; logic [3:0] bits;} row_type;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [17:0] adr = '0;
   logic [3:0] sel = '0;
   logic [31:0] wdat = '0, dat_o, rd;
   logic ack_o, irq_o;
   src_event_type src_event;
   int err_count = 0, n_compared = 0, cycles = 0;
   logic [3:0] vm [6] = '{4'h3, 4'h1, 4'h1, 4'h6, 4'hf, 4'h1};
   row_type rows [11] = '{
      '{11'h400, PROG_TIMER_IRQ_FLAGS_IDX, 4'h1}, '{11'h200, PROG_TIMER_IRQ_FLAGS_IDX, 4'h2},
      '{11'h100, SERIAL_IRQ_FLAG_IDX, 4'h1}, '{11'h080, KEY_GROUP0_IRQ_FLAG_IDX, 4'h1},
      '{11'h040, KEY_GROUP12_IRQ_FLAGS_IDX, 4'h2}, '{11'h020, KEY_GROUP12_IRQ_FLAGS_IDX, 4'h4},
      '{11'h010, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h1}, '{11'h008, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h2},
      '{11'h004, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h4}, '{11'h002, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h8},
      '{11'h001, ADC_IRQ_FLAG_IDX, 4'h1}};

   always #5 clk_i = ~clk_i;

   irq_flags_masks i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .src_event_i(src_event), .irq_o(irq_o));
   event_source_model i_src (.clk_i(clk_i), .src_event_o(src_event));

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task wb(input logic w, input logic [15:0] idx, input logic [3:0] s, input logic [3:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      wdat <= {28'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // Cut a hang short well beyond the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, 16'hffe2 + 16'(i), 4'h1, 4'h0);
         chk(rd, 32'h0);
         wb(1'b0, 16'hfff2 + 16'(i), 4'h1, 4'h0);
         chk(rd, 32'h0);
      end
      $display("test reset values done");
      for (int r = 0; r < 11; r++) begin
         wb(1'b1, rows[r].idx - 16'h0010, 4'h1, rows[r].bits);
         wb(1'b0, rows[r].idx - 16'h0010, 4'h1, 4'h0);
         chk(rd, {28'h0, rows[r].bits});
         i_src.pulse(rows[r].ev);
         wb(1'b0, rows[r].idx, 4'h1, 4'h0);
         chk(rd, {28'h0, rows[r].bits});
         chk({31'h0, irq_o}, 32'h1);
         wb(1'b1, rows[r].idx, 4'h1, 4'hf);
         wb(1'b0, rows[r].idx, 4'h1, 4'h0);
         chk(rd, 32'h0);
         chk({31'h0, irq_o}, 32'h0);
         wb(1'b1, rows[r].idx - 16'h0010, 4'h1, 4'h0);
      end
      $display("test event table done");
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, 16'hffe2 + 16'(i), 4'h1, 4'hf);
         wb(1'b0, 16'hffe2 + 16'(i), 4'h1, 4'h0);
         chk(rd, {28'h0, vm[i]});
      end
      wb(1'b1, 16'h1234, 4'h1, 4'hf);
      wb(1'b0, 16'h1234, 4'h1, 4'h0);
      chk(rd, 32'h0);
      $display("test unused bits done");
      // Two taps pending while only the 8 Hz tap is enabled
      wb(1'b1, CLOCK_TAP_IRQ_MASK_IDX, 4'h1, 4'h2);
      i_src.pulse(11'h012);
      wb(1'b0, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h1, 4'h0);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b1, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h1, 4'h1);
      wb(1'b1, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h0, 4'hf);
      wb(1'b0, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h1, 4'h0);
      chk(rd, 32'h8);
      wb(1'b1, CLOCK_TAP_IRQ_MASK_IDX, 4'h1, 4'h8);
      chk({31'h0, irq_o}, 32'h1);
      $display("test partial clear done");
      // Event and write-one clear land on the same edge: the event must win
      fork
         i_src.pulse(11'h001);
         wb(1'b1, ADC_IRQ_FLAG_IDX, 4'h1, 4'h1);
      join
      wb(1'b0, ADC_IRQ_FLAG_IDX, 4'h1, 4'h0);
      chk(rd, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      $display("test set beats clear done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CLOCK_TAP_IRQ_FLAGS_IDX, 4'h1, 4'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b0, CLOCK_TAP_IRQ_MASK_IDX, 4'h1, 4'h0);
      chk(rd, 32'h0);
      $display("test mid reset done");
      stop_test();
   end
endmodule : tb_irq_flags_masks
